// ---- rtl/psrp_host.sv ----
// Purpose: Host-side controller that drives a 512K x 8 pseudo static RAM through its pins.
// Assumes: One clock, asynchronous active-low reset, memory powered with the controller.
// Notes: Accesses are single words; periodic auto refresh and user-requested self refresh.
//
// What this block does
// - Address is taken at chip select fall; host holds it steady meanwhile.
// - Write data is taken at first rising edge of strobe or select.
// - Auto refresh pulse stays within 8,000 ns; device uses its row counter.
// - Self refresh holds the refresh pin low at least 8,000 ns.
// - Host refreshes all 2048 rows within every 32 ms.
// - After power-up, select stays high for 100 us before any access.
// - After self refresh, wait the exit delay before lowering select.
`timescale 1ns/1ps
module psrp_host
    import psrp_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire psrp_req_t req_in,
    input wire logic req_valid_in,
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic [DATA_W-1:0] rsp_rdata_out,
    input wire logic sleep_req_in,
    output logic sleeping_out,
    output psrp_pins_t pins_out,
    input wire logic [DATA_W-1:0] data_pins_in
);

    psrp_state_t state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [TMR_W-1:0] ref_tmr_ff, nxt_ref_tmr;
    logic ref_pend_ff, nxt_ref_pend;
    psrp_req_t req_ff, nxt_req;
    logic rsp_valid_ff, nxt_rsp_valid;
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;
    psrp_pins_t pins_ff, nxt_pins;
    logic [DATA_W-1:0] dsync1_ff, dsync2_ff;

    // The read data pins come from another chip, so they pass two flops first.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dsync1_ff <= 8'h00;
            dsync2_ff <= 8'h00;
        end else begin
            dsync1_ff <= data_pins_in;
            dsync2_ff <= dsync1_ff;
        end
    end

    // Sequencer: power-up pause, accesses, refresh and self refresh.
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff + 12'h001;
        nxt_req = req_ff;
        nxt_rsp_valid = 1'b0;
        nxt_rdata = rdata_ff;
        nxt_ref_tmr = ref_tmr_ff + 9'h001;
        nxt_ref_pend = ref_pend_ff;
        if (ref_tmr_ff == TMR_W'(REF_INT_CYC - 1)) begin
            nxt_ref_tmr = 9'h000;
        end
        case (state_ff)
            S_PAUSE: begin
                nxt_ref_tmr = 9'h000;
                if (cnt_ff == CNT_W'(PAUSE_CYC - 1)) begin
                    nxt_state = S_IDLE;
                end
            end
            S_IDLE: begin
                if (ref_pend_ff) begin
                    nxt_state = S_AREF;
                end else if (sleep_req_in) begin
                    nxt_state = S_SREF;
                end else if (req_valid_in) begin
                    nxt_req = req_in;
                    nxt_state = req_in.write ? S_WR : S_RD;
                end
            end
            S_RD: begin
                if (cnt_ff == CNT_W'(RD_CYC - 1)) begin
                    nxt_rdata = dsync2_ff;
                    nxt_rsp_valid = 1'b1;
                    nxt_state = S_PRE;
                end
            end
            S_WR: begin
                if (cnt_ff == CNT_W'(WR_CYC - 1)) begin
                    nxt_state = S_WR_END;
                end
            end
            S_WR_END: begin
                nxt_rsp_valid = 1'b1;
                nxt_state = S_PRE;
            end
            S_PRE: begin
                if (cnt_ff == CNT_W'(PRE_CYC - 1)) begin
                    nxt_state = S_IDLE;
                end
            end
            S_AREF: begin
                if (cnt_ff == CNT_W'(FC_CYC - 1)) begin
                    nxt_state = S_IDLE;
                end
            end
            S_SREF: begin
                // The device refreshes itself here, so the interval timer restarts.
                nxt_ref_tmr = 9'h000;
                if (cnt_ff >= CNT_W'(SREF_CYC - 1)) begin
                    nxt_cnt = cnt_ff;
                    if (!sleep_req_in) begin
                        nxt_state = S_SEXIT;
                    end
                end
            end
            S_SEXIT: begin
                if (cnt_ff == CNT_W'(SEXIT_CYC - 1)) begin
                    nxt_state = S_IDLE;
                end
            end
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
        if (nxt_state != state_ff) begin
            nxt_cnt = 12'h000;
        end
        // A timer wrap in the same cycle as an auto refresh start keeps the new request.
        if (ref_tmr_ff == TMR_W'(REF_INT_CYC - 1) && state_ff != S_SREF) begin
            nxt_ref_pend = 1'b1;
        end else if (nxt_state == S_AREF || nxt_state == S_SREF) begin
            nxt_ref_pend = 1'b0;
        end
    end

    // Pin values follow the next state so that every pin leaves a flop.
    always_comb begin
        nxt_pins.chip_sel_n = !(nxt_state inside {S_RD, S_WR, S_WR_END});
        nxt_pins.rw = (nxt_state != S_WR);
        nxt_pins.output_gate_refresh_n = !((nxt_state == S_RD) || (nxt_state == S_SREF)
            || (nxt_state == S_AREF && nxt_cnt < CNT_W'(AREF_LOW_CYC)));
        nxt_pins.data_oe_n = !(nxt_state inside {S_WR, S_WR_END});
        nxt_pins.addr_lines = nxt_req.addr;
        nxt_pins.data_pins = nxt_req.wdata;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff <= S_PAUSE;
            cnt_ff <= 12'h000;
            ref_tmr_ff <= 9'h000;
            ref_pend_ff <= 1'b0;
            req_ff <= '0;
            rsp_valid_ff <= 1'b0;
            rdata_ff <= 8'h00;
            pins_ff <= {1'b1, 1'b1, 1'b1, 19'h00000, 8'h00, 1'b1};
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            ref_tmr_ff <= nxt_ref_tmr;
            ref_pend_ff <= nxt_ref_pend;
            req_ff <= nxt_req;
            rsp_valid_ff <= nxt_rsp_valid;
            rdata_ff <= nxt_rdata;
            pins_ff <= nxt_pins;
        end
    end

    // Ready is combinational: the request is taken in the same cycle it is seen.
    assign req_ready_out = (state_ff == S_IDLE) && !ref_pend_ff && !sleep_req_in;
    assign rsp_valid_out = rsp_valid_ff;
    assign rsp_rdata_out = rdata_ff;
    assign sleeping_out = (state_ff == S_SREF);
    assign pins_out = pins_ff;

    // Helper counters that measure pin behaviour for the checks below.
    logic [7:0] low_run_ff;
    logic self_done_ff;
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            low_run_ff <= 8'h00;
            self_done_ff <= 1'b0;
        end else begin
            // Reads also pull the gate pin low, but only a pulse with select high is a refresh.
            low_run_ff <= (pins_ff.output_gate_refresh_n || !pins_ff.chip_sel_n) ? 8'h00 :
                (low_run_ff == 8'hFF ? low_run_ff : low_run_ff + 8'h01);
            if (!pins_ff.chip_sel_n) begin
                self_done_ff <= 1'b0;
            end else if (!pins_ff.output_gate_refresh_n && low_run_ff >= 8'(SREF_CYC - 1)) begin
                self_done_ff <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_addr_hold;
        !pins_ff.chip_sel_n |=> pins_ff.chip_sel_n || $stable(pins_ff.addr_lines);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved under select");

    sequence s_wr_edge;
        !pins_ff.chip_sel_n && $rose(pins_ff.rw);
    endsequence
    property p_wr_data;
        s_wr_edge |-> !pins_ff.data_oe_n && $stable(pins_ff.data_pins) ##1 pins_ff.chip_sel_n;
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("write data not held at strobe");

    property p_aref_short;
        $rose(pins_ff.output_gate_refresh_n) && low_run_ff != 8'h00 && low_run_ff < 8'(SREF_CYC)
            |-> low_run_ff <= 8'(AREF_LOW_CYC) && $past(pins_ff.chip_sel_n);
    endproperty
    a_aref_short: assert property (p_aref_short) else $error("auto refresh pulse bad");

    property p_sref_min;
        $rose(pins_ff.output_gate_refresh_n) && low_run_ff > 8'(AREF_LOW_CYC)
            |-> low_run_ff >= 8'(SREF_CYC);
    endproperty
    a_sref_min: assert property (p_sref_min) else $error("self refresh pulse short");

    property p_ref_due;
        ref_pend_ff && state_ff == S_IDLE |=> state_ff == S_AREF;
    endproperty
    a_ref_due: assert property (p_ref_due) else $error("refresh not started");

    property p_ref_soon;
        $rose(ref_pend_ff) |-> ##[1:12] !ref_pend_ff;
    endproperty
    a_ref_soon: assert property (p_ref_soon) else $error("refresh left pending");

    property p_pause;
        state_ff == S_PAUSE |-> pins_ff.chip_sel_n && pins_ff.output_gate_refresh_n;
    endproperty
    a_pause: assert property (p_pause) else $error("pins active during pause");

    sequence s_exit_gap;
        (pins_ff.chip_sel_n && pins_ff.output_gate_refresh_n) [*5];
    endsequence
    property p_exit;
        $rose(pins_ff.output_gate_refresh_n) && self_done_ff |-> s_exit_gap;
    endproperty
    a_exit: assert property (p_exit) else $error("select lowered too soon");

endmodule : psrp_host

// ---- pkg/psrp_pkg.sv ----
// Purpose: Shared constants, types and pin bundle for the pseudo static RAM host port.
// Assumes: A 25 MHz system clock and the slowest speed grade of the memory.
// Notes: Every timing count is derived from a time in nanoseconds and the clock period.
package psrp_pkg;

    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int WORDS = 524288;
    localparam int CLK_NS = 40;
    localparam int SYNC_DEPTH = 2;

    // Least times round up, longest times round down.
    localparam int PAUSE_NS = 100000;
    localparam int CE_ACC_NS = 100;
    localparam int CE_PRE_NS = 50;
    localparam int WR_PULSE_NS = 30;
    localparam int AREF_PULSE_MIN_NS = 30;
    localparam int AUTO_REFRESH_PULSE_MAX_NS = 8000;
    localparam int AREF_CYCLE_NS = 160;
    localparam int SELF_REFRESH_PULSE_MIN_NS = 8000;
    localparam int REFRESH_EXIT_DELAY_NS = 190;
    localparam int REF_PERIOD_NS = 32000000;
    localparam int REF_ROWS = 2048;
    localparam int REF_INT_NS = REF_PERIOD_NS / REF_ROWS;

    localparam int PAUSE_CYC = (PAUSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_CYC = (CE_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_DEPTH;
    localparam int WR_CYC = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS + 2;
    localparam int PRE_CYC = (CE_PRE_NS + CLK_NS - 1) / CLK_NS;
    localparam int AREF_LOW_CYC = (AREF_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int AREF_MAX_CYC = AUTO_REFRESH_PULSE_MAX_NS / CLK_NS;
    localparam int FC_CYC = (AREF_CYCLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SREF_CYC = (SELF_REFRESH_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int SEXIT_CYC = (REFRESH_EXIT_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int REF_INT_CYC = REF_INT_NS / CLK_NS;

    localparam int CNT_W = 12;
    localparam int TMR_W = 9;

    typedef enum logic [3:0] {
        S_PAUSE, S_IDLE, S_RD, S_WR, S_WR_END, S_PRE, S_AREF, S_SREF, S_SEXIT
    } psrp_state_t;

    // One access request from the user side.
    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } psrp_req_t;

    // Everything the controller drives toward the memory pins.
    typedef struct packed {
        logic chip_sel_n;
        logic output_gate_refresh_n;
        logic rw;
        logic [ADDR_W-1:0] addr_lines;
        logic [DATA_W-1:0] data_pins;
        logic data_oe_n;
    } psrp_pins_t;

endpackage : psrp_pkg

// ---- test/psrp_mem_model.sv ----
// Purpose: Behavioural pseudo static RAM that answers the host port's pins.
// Assumes: Pins come from registered outputs, so all fields change together.
// Notes: Unwritten bytes read as an address pattern; released data shows inverted.
`timescale 1ns/1ps
module psrp_mem_model
    import psrp_pkg::*;
(
    input wire psrp_pins_t pins_in,
    output logic [DATA_W-1:0] data_pins_out,
    output int auto_cnt_out,
    output int self_cnt_out,
    output int max_gap_out,
    output int min_exit_out,
    output int clash_out
);
    logic [DATA_W-1:0] mem_ff [int];
    logic [ADDR_W-1:0] addr_ff = '0;
    logic [DATA_W-1:0] last_ff = 8'h00;
    logic [10:0] row_ff = '0;
    logic drive;
    int fall_t = -1;
    int end_t = 0;
    int self_end_t = 0;

    // Counters start clean so the bench can compare absolute values.
    initial begin
        auto_cnt_out = 0;
        self_cnt_out = 0;
        max_gap_out = 0;
        min_exit_out = 1000000000;
        clash_out = 0;
    end

    // A byte taken while the host is not driving is garbage, as on a real bus.
    function automatic logic [DATA_W-1:0] wr_byte();
        return pins_in.data_oe_n ? ~last_ff : pins_in.data_pins;
    endfunction : wr_byte

    // Address is taken only at the select fall; the exit delay is measured there too.
    always @(negedge pins_in.chip_sel_n) begin
        addr_ff = pins_in.addr_lines;
        if (self_end_t > 0 && int'($realtime) - self_end_t < min_exit_out) begin
            min_exit_out = int'($realtime) - self_end_t;
        end
        self_end_t = 0;
    end

    // Write data is taken at whichever strobe rises first.
    always @(posedge pins_in.rw) if (!pins_in.chip_sel_n) mem_ff[addr_ff] = wr_byte();
    always @(posedge pins_in.chip_sel_n) if (!pins_in.rw) mem_ff[addr_ff] = wr_byte();

    // A refresh pulse counts only with select high; its width picks the kind.
    always @(negedge pins_in.output_gate_refresh_n) if (pins_in.chip_sel_n) begin
        fall_t = int'($realtime);
        if (end_t > 0 && fall_t - end_t > max_gap_out) max_gap_out = fall_t - end_t;
    end
    always @(posedge pins_in.output_gate_refresh_n) if (pins_in.chip_sel_n && fall_t >= 0) begin
        if (int'($realtime) - fall_t < AUTO_REFRESH_PULSE_MAX_NS) begin
            row_ff = row_ff + 11'h001;
            auto_cnt_out++;
        end else begin
            self_cnt_out++;
            self_end_t = int'($realtime);
        end
        end_t = int'($realtime);
        fall_t = -1;
    end

    // Data is driven only in the read state; otherwise the lines show the last byte inverted.
    always @(pins_in or addr_ff) begin
        drive = !pins_in.chip_sel_n && !pins_in.output_gate_refresh_n && pins_in.rw;
        if (drive) begin
            last_ff = mem_ff.exists(addr_ff) ? mem_ff[addr_ff] : (addr_ff[7:0] ^ 8'hA5);
            data_pins_out = last_ff;
        end else begin
            data_pins_out = ~last_ff;
        end
        if (drive && !pins_in.data_oe_n) clash_out++;
    end
endmodule : psrp_mem_model

// ---- test/psrp_host_bench.sv ----
// Purpose: Self-checking bench for the pseudo static RAM host port.
// Assumes: The memory model sits on the pins; reset values as handed over.
// Notes: Seeded random accesses with corner addresses, auto and self refresh.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((e) !== (g)) begin fails++; \
    $display("BAD %s expected %0h seen %0h", n, e, g); end end
module psrp_host_bench
    import psrp_pkg::*;
();
    logic sys_clk_in = 1'b0;
    logic rst_n_in;
    psrp_req_t req_in;
    logic req_valid_in;
    logic sleep_req_in;
    logic req_ready_out;
    logic rsp_valid_out;
    logic sleeping_out;
    logic [DATA_W-1:0] rsp_rdata_out;
    logic [DATA_W-1:0] data_pins_in;
    psrp_pins_t pins_out;
    int auto_cnt, self_cnt, max_gap, min_exit, clash;
    int fails = 0;
    int total_checks = 0;
    logic [DATA_W-1:0] shadow [int];

    psrp_host i_psrp_host (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .req_in(req_in),
        .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
        .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out),
        .sleep_req_in(sleep_req_in), .sleeping_out(sleeping_out), .pins_out(pins_out),
        .data_pins_in(data_pins_in));
    psrp_mem_model i_psrp_mem_model (.pins_in(pins_out), .data_pins_out(data_pins_in),
        .auto_cnt_out(auto_cnt), .self_cnt_out(self_cnt), .max_gap_out(max_gap),
        .min_exit_out(min_exit), .clash_out(clash));

    // Clock of 40 ns period.
    always #20 sys_clk_in = ~sys_clk_in;

    // Expected byte: last write, or the model's pattern for untouched places.
    function automatic logic [DATA_W-1:0] expect_byte(input logic [ADDR_W-1:0] a);
        return shadow.exists(a) ? shadow[a] : (a[7:0] ^ 8'hA5);
    endfunction : expect_byte

    // Single exit of the run.
    task report_and_stop();
        $display("Counts: %0d checks, %0d mismatches", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    // A wait that ran out of its bound ends the run as a mismatch.
    task guard(input int n, input int lim);
        if (n >= lim) begin
            fails++;
            $display("BAD wait expected done seen expired");
            report_and_stop();
        end
    endtask : guard

    // One request raised once ready is seen and held for one cycle; lat counts falling edges up to the answer.
    task access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                output int lat);
        int n;
        n = 0;
        while (!req_ready_out && n < 1000) begin
            @(negedge sys_clk_in);
            n++;
        end
        guard(n, 1000);
        req_in = '{write: wr, addr: a, wdata: d};
        req_valid_in = 1'b1;
        @(negedge sys_clk_in);
        req_valid_in = 1'b0;
        lat = 1;
        while (!rsp_valid_out && lat < 40) begin
            @(negedge sys_clk_in);
            lat++;
        end
        guard(lat, 40);
    endtask : access

    // Main sequence: pause, accesses, idle refresh, self refresh.
    initial begin
        int n, lat, cs_low;
        logic [ADDR_W-1:0] a, b;
        logic [DATA_W-1:0] d;
        rst_n_in = 1'b0;
        req_in = '0;
        req_valid_in = 1'b0;
        sleep_req_in = 1'b0;
        n = $urandom(4020);
        repeat (16) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        n = 0;
        cs_low = 0;
        while (!req_ready_out && n < 3000) begin
            @(negedge sys_clk_in);
            n++;
            if (pins_out.chip_sel_n !== 1'b1) cs_low++;
        end
        guard(n, 3000);
        `CHK("pause length", 1'b1, n >= PAUSE_CYC - 1)
        `CHK("select low in pause", 0, cs_low)
        for (int i = 0; i < 24; i++) begin
            a = (i == 0) ? '0 : (i == 1) ? ADDR_W'(WORDS - 1) : ADDR_W'($urandom_range(WORDS - 1));
            b = ADDR_W'($urandom_range(WORDS - 1));
            d = DATA_W'($urandom);
            access(1'b1, a, d, lat);
            shadow[a] = d;
            `CHK("write latency", 5, lat)
            access(1'b0, a, ~d, lat);
            `CHK("read back", expect_byte(a), rsp_rdata_out)
            `CHK("read latency", 1'b1, lat == 6 || lat == 7)
            access(1'b0, b, d, lat);
            `CHK("read other", expect_byte(b), rsp_rdata_out)
        end
        n = auto_cnt;
        repeat (2000) @(negedge sys_clk_in);
        `CHK("idle auto refreshes", 1'b1, auto_cnt - n >= 2000 / REF_INT_CYC)
        `CHK("no long pulse", 0, self_cnt)
        // Slack of 20 cycles covers a refresh waiting behind one access.
        `CHK("refresh spacing", 1'b1, max_gap <= REF_INT_NS + 20 * CLK_NS)
        sleep_req_in = 1'b1;
        n = 0;
        while (!sleeping_out && n < 500) begin
            @(negedge sys_clk_in);
            n++;
        end
        guard(n, 500);
        `CHK("refused asleep", 1'b0, req_ready_out)
        repeat (300) @(negedge sys_clk_in);
        `CHK("select high asleep", 1'b1, pins_out.chip_sel_n)
        sleep_req_in = 1'b0;
        access(1'b0, a, 8'h00, lat);
        `CHK("data after sleep", expect_byte(a), rsp_rdata_out)
        `CHK("long pulses", 1, self_cnt)
        `CHK("exit delay", 1'b1, min_exit >= REFRESH_EXIT_DELAY_NS)
        `CHK("data clash", 0, clash)
        report_and_stop();
    end
endmodule : psrp_host_bench
